// ---- src/tio_pkg.sv ----
/*
 File: constants for the timed I/O port block (one port with clock blocks).
 Assumes: a single 20 MHz clock; core requests on a plain register-style port.
*/
// Functional notes
// (R1) port width fixed per instance; whole port is input or output only
// (R2) port drives pins or samples them, optionally waiting on a pin condition
// (R3) every core request is accepted and answered within one cycle
// (R4) open collector: zero drives low, one releases the pin; port-wide
// (R5) data passes through a shift register and a transfer register
// (R6) 16-bit port counter; transfer can wait for a counter match
// (R7) counter readable any time; counter captured as timestamp per transfer
// (R8) an enabled link disables port function on its pins
// (R9) narrower port overrides wider one only on the shared pins
// (R10) port always transfers at its declared width
// (R11) six clock blocks; block 0 is the reference clock, others programmable
// (R12) a clock block may take a 1-bit port input as source, optionally divided
// (R13) input strobe qualifies data in; output strobe accompanies data out
// (R14) after reset the port uses clock block 0
// (R15) pin conditions raise events to the scheduler, not interrupts; the code also sets status bit COND, which raises irq_o when enabled
// (R16) in reset every pin has its pull-down enabled
// (R17) counter advances on each clock-block tick and wraps to zero
// (R18) an unfinished request stalls only the issuing core
package tio_pkg;
	localparam int unsigned TIO_NUM_CLKBLK = 6;
	localparam int unsigned TIO_CNT_W = 16;
	localparam int unsigned TIO_DIV_W = 8;
	localparam logic [2:0] TIO_CLKBLK_RST = 3'h0;
	localparam int unsigned TIO_REF_HZ = 20000000;
	// register word indices
	localparam logic [3:0] TIO_REG_DATA = 4'h0;
	localparam logic [3:0] TIO_REG_CTRL = 4'h1;
	localparam logic [3:0] TIO_REG_COND = 4'h2;
	localparam logic [3:0] TIO_REG_TIME = 4'h3;
	localparam logic [3:0] TIO_REG_COUNT = 4'h4;
	localparam logic [3:0] TIO_REG_STAMP = 4'h5;
	localparam logic [3:0] TIO_REG_STATUS = 4'h6;
	localparam logic [3:0] TIO_REG_IRQ_EN = 4'h7;
	localparam logic [3:0] TIO_REG_IRQ_CLR = 4'h8;
	localparam logic [3:0] TIO_REG_CLKDIV = 4'h9;
	// control fields
	localparam int unsigned TIO_CTRL_EN = 0;
	localparam int unsigned TIO_CTRL_OUT = 1;
	localparam int unsigned TIO_CTRL_OC = 2;
	localparam int unsigned TIO_CTRL_STB_IN = 3;
	localparam int unsigned TIO_CTRL_STB_OUT = 4;
	localparam int unsigned TIO_CTRL_CBLK = 5;
	localparam int unsigned TIO_CTRL_SRC = 8;
	// condition modes
	localparam logic [1:0] TIO_COND_NONE = 2'h0;
	localparam logic [1:0] TIO_COND_EQ = 2'h1;
	localparam logic [1:0] TIO_COND_NEQ = 2'h2;
	// status bits
	localparam int unsigned TIO_ST_XFER = 0;
	localparam int unsigned TIO_ST_COND = 1;
	localparam int unsigned TIO_ST_OVR = 2;
	localparam int unsigned TIO_ST_W = 3;
	typedef enum logic [1:0] {
		TIO_IDLE,
		TIO_WAIT,
		TIO_SHIFT
	} tio_state_t;
endpackage

// ---- src/tio_port.sv ----
/*
 File: one timed I/O port with its clock blocks and a register port.
 Assumes: pins and link enable synchronous to clk_i; testbench resolves wires.
*/
`timescale 1ns/1ns
`default_nettype none
module tio_port #(
	parameter int unsigned WIDTH = 4,
	parameter int unsigned SHIFT = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic stall_o,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe_o,
	output logic [WIDTH-1:0] pin_pd_o,
	input wire logic link_en_i,
	input wire logic [WIDTH-1:0] narrow_claim_i,
	input wire logic [tio_pkg::TIO_NUM_CLKBLK-1:0] clk_src_pin_i,
	input wire logic strobe_in_i,
	output logic strobe_out_qualifier_o,
	output logic event_o,
	output logic irq_o
);
	import tio_pkg::*;
	localparam int unsigned DW = WIDTH * SHIFT;
	localparam logic [TIO_CNT_W-1:0] CNT_ONE = 16'h0001;

	logic [8:0] ctrl_q, ctrl_d;
	logic [1:0] cmode_q, cmode_d;
	logic [WIDTH-1:0] cval_q, cval_d;
	logic [TIO_CNT_W-1:0] tgt_q, tgt_d;
	logic tgt_en_q, tgt_en_d;
	logic [TIO_DIV_W-1:0] div_q, div_d;
	logic [TIO_DIV_W-1:0] dcnt_q, dcnt_d;
	logic src_prev_q, src_prev_d;
	logic [TIO_CNT_W-1:0] cnt_q, cnt_d;
	logic [TIO_CNT_W-1:0] stamp_q, stamp_d;
	logic [DW-1:0] xfer_q, xfer_d;
	logic xfer_full_q, xfer_full_d;
	logic [DW-1:0] ser_q, ser_d;
	logic [7:0] scnt_q, scnt_d;
	logic [WIDTH-1:0] out_q, out_d;
	logic stb_q, stb_d;
	logic [TIO_ST_W-1:0] st_q, st_d, ien_q, ien_d;
	logic [31:0] rdata_q, rdata_d;
	logic ev_q, ev_d;
	tio_state_t state_q, state_d;

	logic en, is_out, oc, tick, src_lvl, cond_ok, time_ok, go, stb_ok;
	logic [2:0] cblk;
	logic [TIO_ST_W-1:0] st_set;
	logic [WIDTH-1:0] own;
	// next deserializer word; also legal when SHIFT is 1
	logic [DW-1:0] shin;

	assign shin = DW'({pin_i, ser_q} >> WIDTH);

	assign en = ctrl_q[TIO_CTRL_EN];
	assign is_out = ctrl_q[TIO_CTRL_OUT];
	assign oc = ctrl_q[TIO_CTRL_OC];
	assign cblk = ctrl_q[TIO_CTRL_CBLK +: 3];
	// link beats narrower port beats this one, per pin
	assign own = (en && !link_en_i) ? ~narrow_claim_i : '0; // R8 R9

	// clock block: 0 is ref tick every cycle; others divide a 1-bit pin
	always_comb begin
		src_lvl = clk_src_pin_i[cblk]; // R12
		src_prev_d = src_lvl;
		dcnt_d = dcnt_q;
		tick = 1'b0;
		if (cblk == TIO_CLKBLK_RST || cblk >= 3'(TIO_NUM_CLKBLK)) begin
			tick = 1'b1; // R11 R14
		end else if (src_lvl && !src_prev_q) begin
			if (dcnt_q >= div_q) begin
				dcnt_d = '0;
				tick = 1'b1;
			end else begin
				dcnt_d = dcnt_q + 8'h01;
			end
		end
	end

	assign cnt_d = tick ? cnt_q + CNT_ONE : cnt_q; // R17 R6
	assign time_ok = !tgt_en_q || (cnt_q == tgt_q); // R6
	always_comb begin
		case (cmode_q)
			TIO_COND_EQ: cond_ok = (pin_i == cval_q);
			TIO_COND_NEQ: cond_ok = (pin_i != cval_q);
			default: cond_ok = 1'b1;
		endcase
	end
	// input strobe gates every transfer step, in or out, when enabled
	assign stb_ok = !ctrl_q[TIO_CTRL_STB_IN] || strobe_in_i; // R13
	assign go = tick && time_ok && stb_ok && (is_out || cond_ok); // R2

	always_comb begin
		ctrl_d = ctrl_q;
		cmode_d = cmode_q;
		cval_d = cval_q;
		tgt_d = tgt_q;
		tgt_en_d = tgt_en_q;
		div_d = div_q;
		ien_d = ien_q;
		xfer_d = xfer_q;
		xfer_full_d = xfer_full_q;
		ser_d = ser_q;
		scnt_d = scnt_q;
		out_d = out_q;
		stb_d = 1'b0;
		stamp_d = stamp_q;
		state_d = state_q;
		st_set = '0;
		ev_d = 1'b0;
		rdata_d = '0;
		if (wr_i) begin
			case (addr_i)
				TIO_REG_DATA: begin
					if (xfer_full_q)
						st_set[TIO_ST_OVR] = 1'b1;
					xfer_d = wdata_i[DW-1:0]; // R5 R10
					xfer_full_d = 1'b1;
				end
				TIO_REG_CTRL: ctrl_d = wdata_i[8:0];
				TIO_REG_COND: begin
					cmode_d = wdata_i[1:0];
					cval_d = wdata_i[8 +: WIDTH];
				end
				TIO_REG_TIME: begin
					tgt_d = wdata_i[15:0];
					tgt_en_d = wdata_i[16];
				end
				TIO_REG_IRQ_EN: ien_d = wdata_i[TIO_ST_W-1:0];
				TIO_REG_CLKDIV: div_d = wdata_i[TIO_DIV_W-1:0];
				default: ;
			endcase
		end
		if (rd_i) begin // R3
			case (addr_i)
				TIO_REG_DATA: begin
					rdata_d = 32'(xfer_q);
					xfer_full_d = 1'b0;
				end
				TIO_REG_CTRL: rdata_d = 32'(ctrl_q);
				TIO_REG_COND: rdata_d = {16'h0000, 8'(cval_q), 6'h00, cmode_q};
				TIO_REG_TIME: rdata_d = {15'h0000, tgt_en_q, tgt_q};
				TIO_REG_COUNT: rdata_d = {16'h0000, cnt_q}; // R7
				TIO_REG_STAMP: rdata_d = {16'h0000, stamp_q}; // R7
				TIO_REG_STATUS: rdata_d = 32'(st_q);
				TIO_REG_IRQ_EN: rdata_d = 32'(ien_q);
				TIO_REG_CLKDIV: rdata_d = 32'(div_q);
				default: rdata_d = '0;
			endcase
		end
		case (state_q)
			TIO_IDLE: begin
				if (en && (is_out ? xfer_full_q : !xfer_full_q)) begin
					if (is_out) begin
						ser_d = xfer_q; // R5
						xfer_full_d = 1'b0;
					end
					state_d = TIO_WAIT;
				end
			end
			TIO_WAIT: begin
				if (go) begin
					stamp_d = cnt_q; // R7
					scnt_d = 8'(SHIFT - 1);
					if (is_out) begin
						out_d = ser_q[WIDTH-1:0];
						ser_d = ser_q >> WIDTH;
						stb_d = ctrl_q[TIO_CTRL_STB_OUT]; // R13
					end else begin
						ser_d = shin;
						if (cmode_q != TIO_COND_NONE) begin
							st_set[TIO_ST_COND] = 1'b1;
							ev_d = 1'b1; // R15
						end
					end
					state_d = (SHIFT == 1) ? TIO_IDLE : TIO_SHIFT;
					if (SHIFT == 1) begin
						st_set[TIO_ST_XFER] = 1'b1;
						if (!is_out) begin
							xfer_d = shin;
							xfer_full_d = 1'b1;
						end
					end
				end
			end
			TIO_SHIFT: begin
				if (tick && stb_ok) begin
					if (is_out) begin
						out_d = ser_q[WIDTH-1:0];
						ser_d = ser_q >> WIDTH;
						stb_d = ctrl_q[TIO_CTRL_STB_OUT];
					end else begin
						ser_d = shin;
					end
					scnt_d = scnt_q - 8'h01;
					if (scnt_q == 8'h01) begin
						state_d = TIO_IDLE;
						st_set[TIO_ST_XFER] = 1'b1;
						if (!is_out) begin
							xfer_d = shin;
							xfer_full_d = 1'b1;
						end
					end
				end
			end
			default: state_d = TIO_IDLE;
		endcase
		if (!en)
			state_d = TIO_IDLE;
		// set wins over a same-cycle clear
		st_d = st_q | st_set;
		if (wr_i && addr_i == TIO_REG_IRQ_CLR)
			st_d = (st_q & ~wdata_i[TIO_ST_W-1:0]) | st_set;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= '0; // R14
			cmode_q <= TIO_COND_NONE;
			cval_q <= '0;
			tgt_q <= '0;
			tgt_en_q <= 1'b0;
			div_q <= '0;
			dcnt_q <= '0;
			src_prev_q <= 1'b0;
			cnt_q <= '0;
			stamp_q <= '0;
			xfer_q <= '0;
			xfer_full_q <= 1'b0;
			ser_q <= '0;
			scnt_q <= '0;
			out_q <= '0;
			stb_q <= 1'b0;
			st_q <= '0;
			ien_q <= '0;
			rdata_q <= '0;
			ev_q <= 1'b0;
			state_q <= TIO_IDLE;
		end else begin
			ctrl_q <= ctrl_d;
			cmode_q <= cmode_d;
			cval_q <= cval_d;
			tgt_q <= tgt_d;
			tgt_en_q <= tgt_en_d;
			div_q <= div_d;
			dcnt_q <= dcnt_d;
			src_prev_q <= src_prev_d;
			cnt_q <= cnt_d;
			stamp_q <= stamp_d;
			xfer_q <= xfer_d;
			xfer_full_q <= xfer_full_d;
			ser_q <= ser_d;
			scnt_q <= scnt_d;
			out_q <= out_d;
			stb_q <= stb_d;
			st_q <= st_d;
			ien_q <= ien_d;
			rdata_q <= rdata_d;
			ev_q <= ev_d;
			state_q <= state_d;
		end
	end

	// whole port one direction; open collector only ever drives zeros
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			pin_o[i] = oc ? 1'b0 : out_q[i]; // R4
			pin_oe_o[i] = own[i] && is_out && (!oc || !out_q[i]); // R1 R4
			pin_pd_o[i] = !rst_n_i; // R16
		end
	end

	// stall only flags this core's own pending work
	assign stall_o = en && (state_q != TIO_IDLE) && // R18
		(is_out ? xfer_full_q : 1'b1);
	assign rdata_o = rdata_q;
	assign strobe_out_qualifier_o = stb_q;
	assign event_o = ev_q;
	assign irq_o = |(st_q & ien_q);
endmodule
`default_nettype wire

// ---- verif/tio_port_assertions.sv ----
/* checker for tio_port pin and bus outputs
 assumes: bound to every tio_port, single clock */
`timescale 1ns/1ns
`default_nettype none
module tio_port_assertions #(
	parameter int unsigned WIDTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [WIDTH-1:0] pin_oe_o,
	input wire logic [WIDTH-1:0] pin_pd_o,
	input wire logic link_en_i,
	input wire logic [WIDTH-1:0] narrow_claim_i,
	input wire logic strobe_out_qualifier_o,
	input wire logic event_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_pd_reset: assert property (disable iff (1'b0)
		!rst_n_i |-> &pin_pd_o) else $error("pull-down off in reset");
	a_quiet_reset: assert property (disable iff (1'b0)
		!rst_n_i |-> pin_oe_o == '0 && rdata_o == '0 && !event_o)
		else $error("output active in reset");
	a_pd_run: assert property (rst_n_i ##1 rst_n_i |-> pin_pd_o == '0)
		else $error("pull-down on after reset");
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == '0)
		else $error("read data outside answer cycle");
	a_link_off: assert property (link_en_i |-> pin_oe_o == '0)
		else $error("pin driven under link");
	a_claim_off: assert property ((pin_oe_o & narrow_claim_i) == '0)
		else $error("claimed pin driven");
	a_strobe_pulse: assert property (
		strobe_out_qualifier_o |=> !strobe_out_qualifier_o)
		else $error("output strobe too long");
	a_event_pulse: assert property ($rose(event_o) |-> ##1 $fell(event_o))
		else $error("event too long");
endmodule
bind tio_port tio_port_assertions #(.WIDTH(WIDTH)) chk_u (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.pin_oe_o(pin_oe_o), .pin_pd_o(pin_pd_o), .link_en_i(link_en_i),
	.narrow_claim_i(narrow_claim_i),
	.strobe_out_qualifier_o(strobe_out_qualifier_o), .event_o(event_o));
`default_nettype wire

// ---- verif/tio_pins_model.sv ----
/* external hardware at the port pins
 assumes: testbench sets the level it drives */
`timescale 1ns/1ns
`default_nettype none
module tio_pins_model #(
	parameter int unsigned W = 4
) (
	input wire logic clk_i,
	input wire logic [W-1:0] pin_o,
	input wire logic [W-1:0] pin_oe_o,
	input wire logic [W-1:0] ext_val_i,
	input wire logic ext_en_i,
	output logic [W-1:0] pin_i,
	output logic strobe_in_o
);
	logic [W-1:0] last_q = '0;
	// a floating pin toggles so a stale level never passes for data
	always_comb begin
		for (int b = 0; b < W; b++) begin
			if (pin_oe_o[b]) begin
				pin_i[b] = pin_o[b];
			end else if (ext_en_i) begin
				pin_i[b] = ext_val_i[b];
			end else begin
				pin_i[b] = ~last_q[b];
			end
		end
	end
	assign strobe_in_o = ext_en_i;
	always @(posedge clk_i) begin
		last_q <= pin_i;
	end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
/* testbench for tio_port: register tasks, directed cases
 assumes: tio_pins_model resolves the pins */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic link_en_i = 1'b0;
	logic ext_en = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [3:0] claim = 4'h0;
	logic [3:0] ext_val = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic [31:0] rdata_o, v, c0;
	logic [3:0] pin_i, pin_o, pin_oe_o, pin_pd_o;
	logic stall_o, sq, event_o, irq_o, stb_in;
	int fail_count = 0;
	int checks = 0;
	always #25 clk_i = ~clk_i;
	tio_port #(.WIDTH(4), .SHIFT(1)) dut_u (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stall_o(stall_o),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.pin_pd_o(pin_pd_o), .link_en_i(link_en_i),
		.narrow_claim_i(claim), .clk_src_pin_i(6'h0),
		.strobe_in_i(stb_in), .strobe_out_qualifier_o(sq),
		.event_o(event_o), .irq_o(irq_o));
	tio_pins_model #(.W(4)) pins_u (.clk_i(clk_i), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
		.pin_i(pin_i), .strobe_in_o(stb_in));
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// waits for an output strobe or an event pulse
	task automatic wp(input logic ev);
		int i;
		for (i = 0; i < 80; i++) begin
			@(posedge clk_i);
			#1;
			if ((ev ? event_o : sq) === 1'b1) break;
		end
		chk("pulse", 32'h0, 32'(i == 80));
	endtask
	task automatic end_of_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#(50 * 2000);
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		chk("pulldown", 32'hf, pin_pd_o);
		rst_n_i <= 1'b1;
		rd(tio_pkg::TIO_REG_CTRL, v);
		chk("clkblk", 32'h0, v[7:5]);
		wr(tio_pkg::TIO_REG_CTRL, 32'h13);
		rd(tio_pkg::TIO_REG_COUNT, c0);
		rd(tio_pkg::TIO_REG_COUNT, v);
		chk("count", c0 + 32'h2, v);
		wr(tio_pkg::TIO_REG_TIME, 32'h10000 | (c0 + 32'h28));
		wr(tio_pkg::TIO_REG_DATA, 32'ha);
		@(posedge clk_i);
		#1 chk("stall", 32'h0, stall_o);
		wp(1'b0);
		chk("pin", 32'ha, pin_o);
		rd(tio_pkg::TIO_REG_STAMP, v);
		chk("stamp", (c0 + 32'h28) & 32'hffff, v);
		wr(tio_pkg::TIO_REG_TIME, 32'h0);
		wr(tio_pkg::TIO_REG_CTRL, 32'h17);
		wr(tio_pkg::TIO_REG_DATA, 32'h5);
		wp(1'b0);
		chk("oc pin", 32'h0, pin_o);
		chk("oc oe", 32'ha, pin_oe_o);
		@(posedge clk_i);
		claim <= 4'h3;
		@(posedge clk_i);
		#1 chk("claim oe", 32'h8, pin_oe_o);
		@(posedge clk_i);
		link_en_i <= 1'b1;
		@(posedge clk_i);
		#1 chk("link oe", 32'h0, pin_oe_o);
		@(posedge clk_i);
		{link_en_i, claim, ext_val, ext_en} <= {1'b0, 4'h0, 4'h3, 1'b1};
		wr(tio_pkg::TIO_REG_COND, 32'h601);
		wr(tio_pkg::TIO_REG_IRQ_EN, 32'h2);
		wr(tio_pkg::TIO_REG_CTRL, 32'h1);
		repeat (5) @(posedge clk_i);
		#1 chk("irq early", 32'h0, irq_o);
		chk("stall in", 32'h1, stall_o);
		@(posedge clk_i);
		ext_val <= 4'h6;
		wp(1'b1);
		@(posedge clk_i);
		ext_val <= 4'h3;
		#1 chk("irq", 32'h1, irq_o);
		rd(tio_pkg::TIO_REG_DATA, v);
		chk("data in", 32'h6, v);
		wr(tio_pkg::TIO_REG_IRQ_CLR, 32'h7);
		@(posedge clk_i);
		#1 chk("irq clr", 32'h0, irq_o);
		rd(4'hf, v);
		chk("unmapped", 32'h0, v);
		end_of_test();
	end
endmodule
`default_nettype wire
